// ==== tseq_trigger_sequencer.v ====
// Trigger sequencer: term matching, level walk, duration and occurrence
// qualifiers, two global timers, pre-trigger storage qualification, APB slave.
// Assumes probe data and the user state clock arrive asynchronously on pins;
// the APB master runs on clk.
//
// How it works
// RULE1: Serial patterns chain one-bit pattern levels
// RULE2: Too-soon uses timer and two levels
// RULE3: Too-late uses timer and two levels
// RULE4: State delay counts anystate occurrences
// RULE5: Term match advances the level statement
// RULE6: Pre-trigger store all, none or qualified
// RULE7: Edge terms only in timing mode
// RULE8: Duration qualifier disables secondary branch
// RULE9: Greater-than needs run length reaching duration
// RULE10: Less-than advances when short run ends
// RULE11: Occurrence counter gates primary; primary wins first
// RULE12: Level entry issues per-timer commands
// RULE13: Exactly two shared global timers
// RULE14: Timer true on expiry; pause until continue
// RULE15: Expiry or stop clears timer count
// RULE16: Level timer commands reset to off
// RULE17: Non-final levels offer two branches
// RULE18: Primary goes next, else secondary same sample
// RULE19: Secondary jumps target; neither stays put
// RULE20: Secondary branch clears occurrence counter
// RULE21: Primary wins when both match
// RULE22: Targets may lie beyond trigger level
// RULE23: Ten masked pattern terms, optional inversion
// RULE24: Span term inclusive of both bounds
// RULE25: Transition term ORs per-channel edges
// RULE26: First level issues no timer commands
// RULE27: Durations count samples (clk cycles in timing mode); timers count clk cycles
`timescale 1ns/100ps
`default_nettype none
`include "tseq_defines.vh"

module tseq_trigger_sequencer (
  input  wire        clk,          // 100 MHz timing sample clock
  input  wire        rst_n,        // Asynchronous reset, active low
  input  wire        psel,         // APB select
  input  wire        penable,      // APB access phase
  input  wire        pwrite,       // APB write when high
  input  wire [11:0] paddr,        // APB byte address
  input  wire [31:0] pwdata,       // APB write data
  output wire [31:0] prdata,       // APB read data
  output wire        pready,       // APB ready
  output wire        pslverr,      // APB error for unmapped address
  input  wire [15:0] probeData,    // Target signals from probes
  input  wire        stateClkPin,  // User state clock from target
  output wire        storeStrobe,  // Write this sample to memory
  output wire [15:0] storeData,    // Sample going to memory
  output wire        triggered,    // Trigger reached, level
  output wire [2:0]  seqLevel      // Current sequence level
);

  // ========================================================================
  // Register storage
  // ========================================================================
  reg  [31:0] ctrl_reg;                       // Run, mode, store mode, trigger level
  reg  [16:0] storeQ_reg;                     // Store qualifier select and invert
  reg  [11:0] invert_reg;                     // Invert flags of patterns and spans
  reg  [31:0] pat_reg   [0:`TSEQ_NUM_PAT-1];  // Care mask high, value low
  reg  [31:0] span_reg  [0:1];                // Upper bound high, lower low
  reg  [31:0] trans_reg [0:1];                // Fall mask high, rise mask low
  reg  [23:0] tmrPre_reg[0:1];                // Timer expiry counts
  reg  [16:0] lvlPri_reg[0:`TSEQ_NUM_LVL-1];  // Primary select and invert
  reg  [19:0] lvlSec_reg[0:`TSEQ_NUM_LVL-1];  // Secondary select, invert, target
  reg  [25:0] lvlQua_reg[0:`TSEQ_NUM_LVL-1];  // Qualifier mode and count
  reg  [6:0]  lvlTmr_reg[0:`TSEQ_NUM_LVL-1];  // Two timer commands

  // APB answer flops
  reg  [31:0] prdata_reg;                     // Registered read data
  reg         pready_reg;                     // High during access phase
  reg         pslverr_reg;                    // Unmapped flag
  reg  [31:0] rdMux;                          // Read data of current address
  reg         rdHit;                          // Address maps to a register

  // Control fields
  wire        runEn      = ctrl_reg[`TSEQ_CTRL_RUN];
  wire        timingMode = ctrl_reg[`TSEQ_CTRL_TIMING];
  wire [1:0]  storeMode  = ctrl_reg[`TSEQ_CTRL_STM_LO+1:`TSEQ_CTRL_STM_LO];
  wire [2:0]  trigLevel  = ctrl_reg[`TSEQ_CTRL_TRG_LO+2:`TSEQ_CTRL_TRG_LO];

  // A write takes effect only at the edge closing the access phase
  wire        wrEn = psel & penable & pwrite & pready_reg;

  // ========================================================================
  // Probe synchronisers
  // ========================================================================
  reg  [15:0] dataS1_reg;     // First stage, read only by second
  reg  [15:0] dataS2_reg;     // Settled sample
  reg         sclkS1_reg;     // First stage, read only by second
  reg         sclkS2_reg;     // Settled state clock
  reg         sclkS3_reg;     // Delayed copy for edge detect
  reg  [15:0] prevD_reg;      // Previous sample for edge terms

  // Timing mode samples every cycle; state mode on rising user clock
  wire        sampleStb = timingMode ? 1'b1 : (sclkS2_reg & ~sclkS3_reg);

  // Two flops on every pin before use
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dataS1_reg <= 16'h0000;
      dataS2_reg <= 16'h0000;
      sclkS1_reg <= 1'b0;
      sclkS2_reg <= 1'b0;
      sclkS3_reg <= 1'b0;
      prevD_reg  <= 16'h0000;
    end else begin
      dataS1_reg <= probeData;
      dataS2_reg <= dataS1_reg;
      sclkS1_reg <= stateClkPin;
      sclkS2_reg <= sclkS1_reg;
      sclkS3_reg <= sclkS2_reg;
      if (sampleStb) begin
        prevD_reg <= dataS2_reg;
      end
    end
  end

  // ========================================================================
  // Resource terms
  // ========================================================================
  wire [15:0] termVec;        // All terms for the current sample
  reg  [1:0]  tmrDone_reg;    // Timer expired, used as a term
  genvar gi;

  // Exact value under care mask, optional inversion
  generate
    for (gi = 0; gi < `TSEQ_NUM_PAT; gi = gi + 1) begin : gPat
      assign termVec[gi] = ~|((dataS2_reg ^ pat_reg[gi][15:0]) & pat_reg[gi][31:16])
                           ^ invert_reg[gi]; // RULE23
    end
  endgenerate

  // Inclusive span and transition terms
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : gSpan
      assign termVec[`TSEQ_TERM_SPAN+gi] =
        ((dataS2_reg >= span_reg[gi][15:0]) && (dataS2_reg <= span_reg[gi][31:16]))
        ^ invert_reg[`TSEQ_TERM_SPAN+gi]; // RULE24
      // Edges only mean something when every cycle is a sample
      assign termVec[`TSEQ_TERM_TRANS+gi] = timingMode & // RULE7
        |((trans_reg[gi][15:0] & dataS2_reg & ~prevD_reg) |
          (trans_reg[gi][31:16] & ~dataS2_reg & prevD_reg)); // RULE25
      assign termVec[`TSEQ_TERM_TMR+gi] = tmrDone_reg[gi]; // RULE12
    end
  endgenerate

  // OR of selected terms, inverted on request; empty select inverted is anystate
  function selHit;
    input [15:0] terms;
    input [16:0] sel;
    begin
      selHit = (|(terms & sel[15:0])) ^ sel[16];
    end
  endfunction

  // ========================================================================
  // Sequencer state
  // ========================================================================
  reg  [2:0]  level_reg;      // Current level
  reg  [2:0]  level_next;
  reg  [23:0] occ_reg;        // Occurrence count in this level
  reg  [23:0] occ_next;
  reg  [23:0] runLen_reg;     // Samples the primary term has stayed true
  reg  [23:0] runLen_next;
  reg         trig_reg;       // Trigger reached, holds until run drops
  reg         trig_next;
  reg         enter_reg;      // Pulse: a level was just entered
  reg         enter_next;
  reg  [2:0]  enterLvl_reg;   // Level that was entered
  reg         store_reg;      // Store strobe to memory
  reg  [15:0] storeD_reg;     // Sample to memory

  wire [16:0] priCfg = lvlPri_reg[level_reg];
  wire [19:0] secCfg = lvlSec_reg[level_reg];
  wire [25:0] quaCfg = lvlQua_reg[level_reg];
  wire [1:0]  qMode  = quaCfg[25:24];
  wire [23:0] qCount = quaCfg[23:0];
  wire        priHit = selHit(termVec, priCfg); // RULE5
  wire        secHit = selHit(termVec, secCfg[16:0]);
  wire        active = runEn & ~trig_reg & sampleStb;
  wire [23:0] occInc = occ_reg + 24'h000001;
  wire [23:0] runInc = runLen_reg + 24'h000001;
  // Duration qualifiers leave only the primary branch; final level has one too
  wire        secOk  = ((qMode == `TSEQ_QM_NONE) || (qMode == `TSEQ_QM_OCC)) && // RULE8
                       (level_reg != trigLevel); // RULE17
  reg         priGo;          // Primary branch taken this sample
  reg         secGo;          // Secondary branch taken this sample

  // Branch decision for one sample
  always @* begin
    case (qMode)
      `TSEQ_QM_NONE: priGo = priHit;
      // Count of zero acts as one; anystate select gives state delay
      `TSEQ_QM_OCC:  priGo = priHit && (occInc >= qCount); // RULE11 RULE4
      // Run length counted in clk cycles of timing samples
      `TSEQ_QM_GT:   priGo = priHit && (runInc >= qCount); // RULE9 RULE27
      // Go on the first false sample after a short enough run
      `TSEQ_QM_LT:   priGo = !priHit && (runLen_reg != 24'h000000) &&
                             (runLen_reg <= qCount); // RULE10
      default:       priGo = 1'b0;
    endcase
    // Secondary looked at in the same sample only if primary fails
    secGo = secOk & secHit & ~priGo; // RULE18 RULE21
  end

  // Next level, counters and trigger
  always @* begin
    level_next  = level_reg;
    occ_next    = occ_reg;
    runLen_next = runLen_reg;
    trig_next   = trig_reg;
    enter_next  = 1'b0;
    if (active) begin
      runLen_next = priHit ? runInc : 24'h000000;
      if ((qMode == `TSEQ_QM_OCC) && priHit) begin
        occ_next = occInc;
      end
      if (priGo) begin
        occ_next    = 24'h000000;
        runLen_next = 24'h000000;
        if (level_reg == trigLevel) begin
          trig_next = 1'b1;
        end else begin
          // Chained single-bit levels walk a serial pattern this way
          level_next = level_reg + 3'h1; // RULE18 RULE1
          enter_next = 1'b1;
        end
      end else if (secGo) begin
        // Any level is legal, even past the trigger level
        level_next  = secCfg[19:17]; // RULE19 RULE22
        occ_next    = 24'h000000; // RULE20
        runLen_next = 24'h000000;
        enter_next  = 1'b1;
      end
      // Neither branch: stay and look again next sample
    end
  end

  // Sequencer flops; a dropped run bit restarts the acquisition
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_reg    <= 3'h0;
      occ_reg      <= 24'h000000;
      runLen_reg   <= 24'h000000;
      trig_reg     <= 1'b0;
      enter_reg    <= 1'b0;
      enterLvl_reg <= 3'h0;
      store_reg    <= 1'b0;
      storeD_reg   <= 16'h0000;
    end else if (!runEn) begin
      level_reg    <= 3'h0;
      occ_reg      <= 24'h000000;
      runLen_reg   <= 24'h000000;
      trig_reg     <= 1'b0;
      enter_reg    <= 1'b0;
      enterLvl_reg <= 3'h0;
      store_reg    <= 1'b0;
      storeD_reg   <= dataS2_reg;
    end else begin
      level_reg    <= level_next;
      occ_reg      <= occ_next;
      runLen_reg   <= runLen_next;
      trig_reg     <= trig_next;
      enter_reg    <= enter_next;
      enterLvl_reg <= level_next;
      // Filter applies before trigger only; afterwards every sample is kept
      store_reg    <= sampleStb & (trig_reg | (storeMode == `TSEQ_STORE_ALL) |
                      ((storeMode == `TSEQ_STORE_QUAL) &
                       selHit(termVec, storeQ_reg))); // RULE6
      storeD_reg   <= dataS2_reg;
    end
  end

  // ========================================================================
  // Global timers, shared by every level
  // ========================================================================
  reg  [23:0] tmrCnt_reg [0:1];  // Accumulated count
  reg  [1:0]  tmrRun_reg;        // Counting enabled

  // Both timers sit in one loop so every level drives the same pair
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : gTmr // RULE13
      wire [2:0]  cmd   = lvlTmr_reg[enterLvl_reg][gi*4+2:gi*4];
      wire        doCmd = enter_reg && (enterLvl_reg != 3'h0); // RULE26
      wire [23:0] cInc  = tmrCnt_reg[gi] + 24'h000001;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          tmrCnt_reg[gi]  <= 24'h000000;
          tmrRun_reg[gi]  <= 1'b0;
          tmrDone_reg[gi] <= 1'b0;
        end else if (!runEn) begin
          tmrCnt_reg[gi]  <= 24'h000000;
          tmrRun_reg[gi]  <= 1'b0;
          tmrDone_reg[gi] <= 1'b0;
        end else if (doCmd && (cmd == `TSEQ_TC_START)) begin
          tmrCnt_reg[gi]  <= 24'h000000;
          tmrRun_reg[gi]  <= 1'b1; // RULE12
          tmrDone_reg[gi] <= 1'b0;
        end else if (doCmd && (cmd == `TSEQ_TC_STOP)) begin
          tmrCnt_reg[gi]  <= 24'h000000; // RULE15
          tmrRun_reg[gi]  <= 1'b0;
          tmrDone_reg[gi] <= 1'b0;
        end else if (doCmd && (cmd == `TSEQ_TC_PAUSE)) begin
          tmrRun_reg[gi]  <= 1'b0; // RULE14
        end else if (doCmd && (cmd == `TSEQ_TC_CONT)) begin
          tmrRun_reg[gi]  <= ~tmrDone_reg[gi]; // RULE14
        end else if (tmrRun_reg[gi]) begin
          // Counts clk cycles; too-soon and too-late windows rest on this
          if (cInc >= tmrPre_reg[gi]) begin // RULE27 RULE2 RULE3
            tmrCnt_reg[gi]  <= 24'h000000; // RULE15
            tmrRun_reg[gi]  <= 1'b0;
            tmrDone_reg[gi] <= 1'b1; // RULE14
          end else begin
            tmrCnt_reg[gi]  <= cInc;
          end
        end
      end
    end
  endgenerate

  // ========================================================================
  // APB read decode
  // ========================================================================
  always @* begin
    rdMux = 32'h00000000;
    rdHit = 1'b1;
    if (paddr[1:0] != 2'h0) begin
      rdHit = 1'b0;
    end else if (paddr == `TSEQ_OFF_CTRL) begin
      rdMux = {21'h000000, ctrl_reg[10:8], 2'h0, ctrl_reg[5:4], 2'h0, ctrl_reg[1:0]};
    end else if (paddr == `TSEQ_OFF_STATUS) begin
      rdMux = {20'h00000, tmrRun_reg, tmrDone_reg, 3'h0, trig_reg, 1'b0, level_reg};
    end else if (paddr == `TSEQ_OFF_STOREQ) begin
      rdMux = {15'h0000, storeQ_reg};
    end else if (paddr == `TSEQ_OFF_INVERT) begin
      rdMux = {20'h00000, invert_reg};
    end else if ((paddr[11:6] == 6'h01) && (paddr[5:2] < 4'hA)) begin
      rdMux = pat_reg[paddr[5:2]];
    end else if (paddr[11:3] == 9'h010) begin
      rdMux = span_reg[paddr[2]];
    end else if (paddr[11:3] == 9'h012) begin
      rdMux = trans_reg[paddr[2]];
    end else if (paddr[11:3] == 9'h014) begin
      rdMux = {8'h00, tmrPre_reg[paddr[2]]};
    end else if (paddr[11:7] == 5'h02) begin
      // Level block: four words per level
      case (paddr[3:2])
        2'h0:    rdMux = {15'h0000, lvlPri_reg[paddr[6:4]]};
        2'h1:    rdMux = {12'h000, lvlSec_reg[paddr[6:4]]};
        2'h2:    rdMux = {6'h00, lvlQua_reg[paddr[6:4]]};
        default: rdMux = {25'h0000000, lvlTmr_reg[paddr[6:4]]};
      endcase
    end else begin
      rdHit = 1'b0;
    end
  end

  // ========================================================================
  // APB answer and register writes
  // ========================================================================
  integer k;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      ctrl_reg    <= `TSEQ_CTRL_RESET;
      storeQ_reg  <= 17'h00000;
      invert_reg  <= 12'h000;
      for (k = 0; k < `TSEQ_NUM_PAT; k = k + 1) begin
        pat_reg[k] <= 32'h00000000;
      end
      for (k = 0; k < 2; k = k + 1) begin
        span_reg[k]   <= 32'hFFFF0000;
        trans_reg[k]  <= 32'h00000000;
        tmrPre_reg[k] <= `TSEQ_TMR_RESET;
      end
      for (k = 0; k < `TSEQ_NUM_LVL; k = k + 1) begin
        lvlPri_reg[k] <= 17'h00000;
        lvlSec_reg[k] <= 20'h00000;
        lvlQua_reg[k] <= 26'h0000000;
        lvlTmr_reg[k] <= 7'h00; // RULE16
      end
    end else begin
      // One-cycle answer: data latched in setup, ready in access
      pready_reg  <= psel & ~penable;
      pslverr_reg <= psel & ~penable & ~rdHit;
      if (psel & ~penable & ~pwrite) begin
        prdata_reg <= rdMux;
      end
      if (wrEn & rdHit) begin
        if (paddr == `TSEQ_OFF_CTRL) begin
          ctrl_reg <= pwdata & 32'h00000733;
        end else if (paddr == `TSEQ_OFF_STOREQ) begin
          storeQ_reg <= pwdata[16:0];
        end else if (paddr == `TSEQ_OFF_INVERT) begin
          invert_reg <= pwdata[11:0];
        end else if (paddr[11:6] == 6'h01) begin
          pat_reg[paddr[5:2]] <= pwdata;
        end else if (paddr[11:3] == 9'h010) begin
          span_reg[paddr[2]] <= pwdata;
        end else if (paddr[11:3] == 9'h012) begin
          trans_reg[paddr[2]] <= pwdata;
        end else if (paddr[11:3] == 9'h014) begin
          tmrPre_reg[paddr[2]] <= pwdata[23:0];
        end else if (paddr[11:7] == 5'h02) begin
          case (paddr[3:2])
            2'h0:    lvlPri_reg[paddr[6:4]] <= pwdata[16:0];
            2'h1:    lvlSec_reg[paddr[6:4]] <= pwdata[19:0];
            2'h2:    lvlQua_reg[paddr[6:4]] <= pwdata[25:0];
            default: lvlTmr_reg[paddr[6:4]] <= pwdata[6:0];
          endcase
        end
        // Status is read only; writes to it are dropped
      end
    end
  end

  // ========================================================================
  // Outputs straight from flops
  // ========================================================================
  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign storeStrobe = store_reg;
  assign storeData   = storeD_reg;
  assign triggered   = trig_reg;
  assign seqLevel    = level_reg;

endmodule

`default_nettype wire

// ==== tseq_defines.vh ====
// Address map, field positions, reset values and codes of the trigger sequencer.
// Assumes inclusion by bare name from the sequencer source; holds definitions only.
`ifndef TSEQ_DEFINES_VH
`define TSEQ_DEFINES_VH

// ==========================================================================
// Register byte offsets on APB
// ==========================================================================
`define TSEQ_OFF_CTRL       12'h000
`define TSEQ_OFF_STATUS     12'h004
`define TSEQ_OFF_STOREQ     12'h008
`define TSEQ_OFF_INVERT     12'h00C
`define TSEQ_OFF_PAT_BASE   12'h040
`define TSEQ_OFF_SPAN_BASE  12'h080
`define TSEQ_OFF_TRANS_BASE 12'h090
`define TSEQ_OFF_TMR_BASE   12'h0A0
`define TSEQ_OFF_LVL_BASE   12'h100

// ==========================================================================
// Sizes
// ==========================================================================
`define TSEQ_NUM_PAT     10
`define TSEQ_NUM_LVL     8
`define TSEQ_DATA_W      16

// ==========================================================================
// Control word fields and reset value
// ==========================================================================
`define TSEQ_CTRL_RUN     0
`define TSEQ_CTRL_TIMING  1
`define TSEQ_CTRL_STM_LO  4
`define TSEQ_CTRL_TRG_LO  8
`define TSEQ_CTRL_RESET   32'h00000000

// ==========================================================================
// Term vector positions
// ==========================================================================
`define TSEQ_TERM_SPAN   10
`define TSEQ_TERM_TRANS  12
`define TSEQ_TERM_TMR    14

// ==========================================================================
// Store modes, qualifier modes, timer commands
// ==========================================================================
`define TSEQ_STORE_ALL   2'h0
`define TSEQ_STORE_NONE  2'h1
`define TSEQ_STORE_QUAL  2'h2
`define TSEQ_QM_NONE     2'h0
`define TSEQ_QM_OCC      2'h1
`define TSEQ_QM_GT       2'h2
`define TSEQ_QM_LT       2'h3
`define TSEQ_TC_OFF      3'h0
`define TSEQ_TC_START    3'h1
`define TSEQ_TC_STOP     3'h2
`define TSEQ_TC_PAUSE    3'h3
`define TSEQ_TC_CONT     3'h4

// ==========================================================================
// Reset values of level words (timer command off) and timer expiry counts
// ==========================================================================
`define TSEQ_LVL_RESET   32'h00000000
`define TSEQ_TMR_RESET   24'h000001

`endif

// ==== tseq_target_model.sv ====
// Target model: probes and bursting state clock.
// Assumes inputs change after rising edges.
`timescale 1ns/100ps
`default_nettype none
module tseq_target_model (
  input  wire logic        clk,                 // Clock
  input  wire logic [15:0] pat,                 // Value to show
  input  wire logic        stGo,                // Burst enable
  output var  logic [15:0] probeData   = 16'h0, // Probe lines
  output var  logic        stateClkPin = 1'h0   // State clock
);
  // ==========
  // Drive
  logic [1:0] div = 2'h0; // Divider
  // Clock stands low between bursts, clk/4 inside
  always @(posedge clk) begin
    probeData   <= pat;
    div         <= stGo ? div + 2'h1 : 2'h0;
    stateClkPin <= stGo & div[1];
  end
endmodule
`default_nettype wire

// ==== tseq_trigger_sequencer_props.sv ====
// Checker of APB timing and trigger hold.
// Assumes a bind onto the sequencer top.
`timescale 1ns/100ps
`default_nettype none
module tseq_props (
  input wire logic        clk,       // Clock
  input wire logic        rst_n,     // Reset, active low
  input wire logic        psel,      // Select
  input wire logic        penable,   // Access
  input wire logic        pwrite,    // Direction
  input wire logic [11:0] paddr,     // Address
  input wire logic [31:0] prdata,    // Read data
  input wire logic        pready,    // Ready
  input wire logic        pslverr,   // Error
  input wire logic        triggered, // Trigger flag
  input wire logic [2:0]  seqLevel   // Level
);
  // ==========
  // Properties
  wire ctlWr = psel && pwrite && paddr == 12'h000; // May clear run
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  rdy_after_setup_a: assert property (psel && !penable |=> pready) else $error("ready late");
  rdy_one_cycle_a: assert property (pready |=> !pready) else $error("ready too long");
  rdy_has_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  err_with_rdy_a: assert property (pslverr |-> pready) else $error("error without ready");
  misalign_err_a: assert property (psel && !penable && !pwrite && paddr[1:0] != 2'h0
    |=> pslverr && prdata == 32'h0) else $error("misaligned read taken");
  unmapped_err_a: assert property (psel && !penable && paddr[11:9] != 3'h0 |=> pslverr)
    else $error("unmapped access taken");
  trig_hold_a: assert property (triggered && !ctlWr && !$past(ctlWr) |=> triggered)
    else $error("trigger dropped");
  lvl_frozen_a: assert property (triggered ##1 triggered |-> $stable(seqLevel))
    else $error("level moved after trigger");
endmodule
bind tseq_trigger_sequencer tseq_props tseq_props_inst (.*);
`default_nettype wire

// ==== test_trigger_sequencer.sv ====
// Bench for the trigger sequencer over APB.
// Assumes all block files compiled with it.
`timescale 1ns/100ps
`default_nettype none
module test_trigger_sequencer;
  // ==========
  // Signals
  logic        clk     = 1'h0;  // Clock
  logic        rst_n   = 1'h0;  // Reset, active low
  logic        psel    = 1'h0;  // Select
  logic        penable = 1'h0;  // Access
  logic        pwrite  = 1'h0;  // Direction
  logic [11:0] paddr   = 12'h0; // Address
  logic [31:0] pwdata  = 32'h0; // Write data
  logic [15:0] pat     = 16'h0; // Target value
  logic        stGo    = 1'h0;  // State burst
  logic [31:0] rd;              // Read data
  logic        rdErr;           // Error seen
  wire  [31:0] prdata;          // Read data
  wire         pready, pslverr, storeStrobe, triggered, stateClkPin;
  wire  [15:0] probeData, storeData;
  wire  [2:0]  seqLevel;
  int          failures   = 0;  // Mismatches
  int          n_compared = 0;  // Comparisons
  int          nStored    = 0;  // Strobes seen
  int          n;               // Strobe mark
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (storeStrobe === 1'h1) nStored <= nStored + 1;
  tseq_trigger_sequencer tseq_trigger_sequencer_inst (.*);
  tseq_target_model tseq_target_model_inst (.*);
  // ==========
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    for (i = 0; i < 20 && pready !== 1'h1; i++) @(posedge clk);
    if (i == 20) failures++;
    if (i == 20) end_sim();
    rd = prdata;
    rdErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic w(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic drv(input logic [15:0] v, input int c);
    pat <= v;
    repeat (c) @(posedge clk);
  endtask
  // Bounded wait for a level and trigger state
  task automatic waitFor(input logic [2:0] l, input logic t);
    int i;
    for (i = 0; i < 40 && {triggered, seqLevel} !== {t, l}; i++) @(posedge clk);
    chk({28'h0, triggered, seqLevel}, {28'h0, t, l});
    if (i == 40) end_sim();
  endtask
  // Stop the run and clear levels 0 to 3
  task automatic clr;
    int l;
    w(12'h000, 32'h0);
    for (l = 0; l < 64; l += 4) w(12'h100 + l[11:0], 32'h0);
  endtask
  // ==========
  // Scenarios
  task automatic tRegs;
    apb(1'h0, 12'h0A0, 32'h0);
    chk(rd, 32'h1);
    apb(1'h0, 12'h084, 32'h0);
    chk(rd, 32'hFFFF0000);
    apb(1'h0, 12'h800, 32'h0);
    chk({31'h0, rdErr}, 32'h1);
    w(12'h004, 32'h1F);
    apb(1'h0, 12'h004, 32'h0);
    chk(rd & 32'h17, 32'h0);
    w(12'h040, 32'hFFFF1234);
    w(12'h044, 32'hFFFF5678);
  endtask
  task automatic tBranch;
    clr();
    w(12'h100, 32'h1);
    w(12'h104, 32'h000A0001);
    w(12'h110, 32'h2);
    w(12'h000, 32'h103);
    drv(16'h1234, 6);
    waitFor(3'h1, 1'h0);
    drv(16'h5678, 1);
    waitFor(3'h1, 1'h1);
  endtask
  task automatic tOccur;
    clr();
    w(12'h100, 32'h1);
    w(12'h104, 32'h2);
    w(12'h108, 32'h01000003);
    w(12'h000, 32'h703);
    drv(16'h1234, 2);
    drv(16'h5678, 1);
    drv(16'h1234, 2);
    drv(16'h0, 6);
    chk({29'h0, seqLevel}, 32'h0);
    drv(16'h1234, 1);
    waitFor(3'h1, 1'h0);
    chk({16'h0, storeData}, 32'h1234);
  endtask
  task automatic tGt;
    drv(16'h0, 1);
    clr();
    w(12'h100, 32'h1);
    w(12'h104, 32'h00070000);
    w(12'h108, 32'h02000004);
    w(12'h110, 32'h10000);
    w(12'h000, 32'h103);
    drv(16'h1234, 3);
    drv(16'h0, 8);
    chk({29'h0, seqLevel}, 32'h0);
    drv(16'h1234, 4);
    waitFor(3'h1, 1'h1);
  endtask
  task automatic tTimer;
    clr();
    w(12'h0A0, 32'h8);
    w(12'h100, 32'h10000);
    w(12'h10C, 32'h10);
    w(12'h11C, 32'h1);
    w(12'h110, 32'h4000);
    w(12'h120, 32'h8000);
    w(12'h000, 32'h203);
    repeat (5) @(posedge clk);
    chk({29'h0, seqLevel}, 32'h1);
    waitFor(3'h2, 1'h0);
    repeat (20) @(posedge clk);
    chk({31'h0, triggered}, 32'h0);
  endtask
  task automatic tStore;
    clr();
    w(12'h008, 32'h1);
    w(12'h000, 32'h713);
    n = nStored;
    drv(16'h1234, 10);
    chk(nStored - n, 32'h0);
    w(12'h000, 32'h723);
    drv(16'h0, 6);
    n = nStored;
    drv(16'h1234, 5);
    drv(16'h0, 8);
    chk(nStored - n, 32'h5);
    w(12'h000, 32'h701);
    drv(16'h0, 6);
    n = nStored;
    stGo <= 1'h1;
    repeat (24) @(posedge clk);
    stGo <= 1'h0;
    repeat (10) @(posedge clk);
    chk(nStored - n, 32'h6);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    tRegs();
    tBranch();
    tOccur();
    tGt();
    tTimer();
    tStore();
    end_sim();
  end
endmodule
`default_nettype wire
